// ==== logic/motor_cmd_pkg.sv ====
// constants, register map and encodings for the motor command source logic
package motor_cmd_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_INPUT_FUNC = 8'h04;
  localparam logic [7:0] OFF_MONITOR = 8'h08;
  localparam logic [7:0] OFF_NODE = 8'h0C;
  localparam logic [7:0] OFF_WATCHDOG = 8'h10;
  localparam logic [7:0] OFF_PANEL_CMD = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_QUANTITY_A = 8'h1C;
  localparam logic [7:0] OFF_QUANTITY_B = 8'h20;
  localparam logic [7:0] OFF_LINK = 8'h24;
  // input function codes
  localparam logic [2:0] FUNC_NONE = 3'h0;
  localparam logic [2:0] FUNC_ERROR_RESET = 3'h1;
  localparam logic [2:0] FUNC_EXT_ERROR = 3'h2;
  localparam logic [2:0] FUNC_GEN_ENABLE = 3'h3;
  localparam logic [2:0] FUNC_SPECIAL = 3'h4;
  localparam logic [2:0] FUNC_MAX = 3'h4;
  // reset values
  localparam logic [2:0] RST_IN2_FUNC = 3'h1;
  localparam logic [2:0] RST_IN3_FUNC = 3'h2;
  localparam logic [2:0] RST_IN4_FUNC = 3'h0;
  localparam logic [2:0] RST_MON_SRC = 3'h0;
  localparam logic [7:0] RST_MON_GAIN = 8'h64;
  localparam logic [4:0] RST_NODE_ADDR = 5'h01;
  localparam logic [5:0] RST_WD_TIME = 6'h00;
  localparam logic [1:0] RST_WD_ACTION = 2'h1;
  localparam logic RST_CMD_SOURCE = 1'b1;
  // limits
  localparam logic [4:0] NODE_ADDR_MIN = 5'h01;
  localparam logic [4:0] NODE_ADDR_MAX = 5'h1E;
  localparam logic [5:0] WD_TIME_MAX = 6'h37;
  // monitor sources
  localparam logic [2:0] MON_OFF = 3'h0;
  localparam logic [2:0] MON_CURRENT = 3'h1;
  localparam logic [2:0] MON_VOLTAGE = 3'h2;
  localparam logic [2:0] MON_PF = 3'h3;
  localparam logic [2:0] MON_THERMAL = 3'h4;
  // percent inputs (power factor in hundredths); unity-gain full scale
  localparam int FS_CURRENT = 500;
  localparam int FS_VOLTAGE = 100;
  localparam int FS_PF = 100;
  localparam int FS_THERMAL = 250;
  localparam int GAIN_UNITY = 100;
  // watchdog expiry actions
  localparam logic [1:0] ACT_REPORT = 2'h1;
  localparam logic [1:0] ACT_RAMP = 2'h2;
  localparam logic [1:0] ACT_EMERGENCY = 2'h3;
  // timing
  localparam int CLK_HZ = 200000000;
  localparam int WD_STEP_S = 1;
  localparam int WD_STEP_CYCLES = CLK_HZ * WD_STEP_S;
  localparam int FLASH_MS = 500;
  localparam int FLASH_CYCLES = CLK_HZ / 1000 * FLASH_MS;
endpackage

// ==== logic/monitor_scaler.sv ====
// scales a selected quantity into the 8-bit monitor code, saturating
`timescale 1ns/1ps
module monitor_scaler
  import motor_cmd_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] source,
  input wire logic [7:0] gain,
  input wire logic [11:0] switch_current,
  input wire logic [11:0] output_voltage,
  input wire logic [11:0] power_factor,
  input wire logic [11:0] motor_thermal_state,
  output logic [7:0] code
);
  logic [11:0] quantity;
  logic [11:0] full_scale;
  logic [31:0] product;
  logic [31:0] scaled;

  always_comb begin
    quantity = 12'h000;
    full_scale = 12'(FS_CURRENT);
    case (source)
      MON_CURRENT: begin
        quantity = switch_current; // [RULE_02]
        full_scale = 12'(FS_CURRENT);
      end
      MON_VOLTAGE: begin
        quantity = output_voltage; // [RULE_03]
        full_scale = 12'(FS_VOLTAGE);
      end
      MON_PF: begin
        quantity = power_factor; // [RULE_04]
        full_scale = 12'(FS_PF);
      end
      MON_THERMAL: begin
        quantity = motor_thermal_state; // [RULE_05]
        full_scale = 12'(FS_THERMAL);
      end
      default: begin
        quantity = 12'h000; // [RULE_01]
        full_scale = 12'(FS_CURRENT);
      end
    endcase
  end

  // q*255*gain/(fs*100); divisor is a constant per source
  assign product = 32'(quantity) * 32'(gain) * 32'h0000_00FF;
  assign scaled = product / (32'(full_scale) * 32'(GAIN_UNITY));

  always_ff @(posedge clk) begin
    if (rst) begin
      code <= 8'h00;
    end else if (scaled > 32'h0000_00FF) begin
      code <= 8'hFF; // [RULE_22]
    end else begin
      code <= scaled[7:0]; // [RULE_01]
    end
  end
endmodule

// ==== logic/motor_command_source_logic.sv ====
// command source selection, enables, errors, watchdog and register slave
`timescale 1ns/1ps
// Contract
// [RULE_01] monitor output shows selected quantity, default off
// [RULE_02] gain scales; current full scale 500 percent
// [RULE_03] voltage full scale at rated voltage
// [RULE_04] power factor full scale at unity
// [RULE_05] thermal full scale at 250 percent
// [RULE_06] source off: start/stop from inputs one, two
// [RULE_07] source on: panel and serial, input one ignored
// [RULE_08] source change only stopped, input one open
// [RULE_09] inching from input four or serial
// [RULE_10] reversal from input three or serial
// [RULE_11] any open enable input stops at once
// [RULE_12] serial enable needs all enable inputs closed
// [RULE_13] external error only from inputs two to four
// [RULE_14] error reset from panel, serial or input pulse
// [RULE_15] node address 1 to 30, default 1
// [RULE_16] watchdog off by default, 1 s steps, 55 max
// [RULE_17] master sends telegrams faster than timeout
// [RULE_18] input four unused by default, codes 1-4
// [RULE_19] expiry action report, ramp stop, or emergency
// [RULE_20] no enable input closed: firing suppressed; with no enable input assigned, firing stays on
// [RULE_21] addressed telegram restarts watchdog count
// [RULE_22] monitor code saturates at 255
module motor_command_source_logic
  import motor_cmd_pkg::*;
#(
  parameter int WD_STEP = WD_STEP_CYCLES,
  parameter int FLASH_LEN = FLASH_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic first_digital_input,
  input wire logic second_digital_input,
  input wire logic third_digital_input,
  input wire logic fourth_digital_input,
  input wire logic motor_stopped,
  input wire logic telegram_valid,
  input wire logic [4:0] telegram_address,
  input wire logic serial_start,
  input wire logic serial_stop,
  input wire logic serial_inching,
  input wire logic serial_reverse,
  input wire logic serial_enable,
  input wire logic serial_error_reset,
  input wire logic [11:0] switch_current,
  input wire logic [11:0] output_voltage,
  input wire logic [11:0] power_factor,
  input wire logic [11:0] motor_thermal_state,
  output logic [7:0] monitor_code,
  output logic run_cmd,
  output logic inching_command,
  output logic reverse_cmd,
  output logic emergency_stop,
  output logic ramp_stop,
  output logic firing_enable,
  output logic external_error,
  output logic serial_timeout_error,
  output logic telegram_accept,
  output logic display_flash
);
  logic [2:0] in2_func_reg, in3_func_reg, input_four_function;
  logic [2:0] monitor_output_source;
  logic [7:0] monitor_output_gain;
  logic command_source_select;
  logic [4:0] network_node_address;
  logic [5:0] serial_watchdog_time;
  logic [1:0] watchdog_expiry_action;
  logic panel_start_reg, panel_stop_reg, panel_reset_reg;
  logic run_reg;
  logic [2:0] din_reg;
  logic [31:0] wd_cycle_reg;
  logic [5:0] wd_sec_reg;
  logic [31:0] flash_cnt_reg;
  logic wr, rd, reset_req, wd_expire, telegram_ours;
  logic [2:0] dins, funcs_ge, funcs_ee, funcs_er, din_rise;
  logic any_ge, all_ge_closed, ge_open, ext_now;
  logic [31:0] rdata_next;

  function automatic logic [2:0] func_match(input logic [2:0] a, input logic [2:0] b,
                                            input logic [2:0] c, input logic [2:0] f);
    func_match = {c == f, b == f, a == f};
  endfunction

  function automatic logic func_legal(input logic [2:0] v);
    func_legal = v <= FUNC_MAX;
  endfunction

  assign wr = avs_write && !avs_waitrequest;
  assign rd = avs_read && !avs_waitrequest;
  assign dins = {fourth_digital_input, third_digital_input, second_digital_input};
  assign funcs_ge = func_match(in2_func_reg, in3_func_reg, input_four_function, FUNC_GEN_ENABLE);
  assign funcs_ee = func_match(in2_func_reg, in3_func_reg, input_four_function, FUNC_EXT_ERROR);
  assign funcs_er = func_match(in2_func_reg, in3_func_reg, input_four_function,
                               FUNC_ERROR_RESET);
  assign din_rise = dins & ~din_reg;
  assign any_ge = |funcs_ge;
  assign ge_open = |(funcs_ge & ~dins); // [RULE_11]
  assign all_ge_closed = !ge_open; // [RULE_12]
  assign ext_now = |(funcs_ee & ~dins); // [RULE_13]
  assign telegram_ours = telegram_valid && telegram_address == network_node_address; // [RULE_15]
  assign reset_req = panel_reset_reg || (serial_error_reset && command_source_select) ||
                     |(funcs_er & din_rise); // [RULE_14]
  assign wd_expire = serial_watchdog_time != 6'h00 && wd_sec_reg == serial_watchdog_time &&
                     wd_cycle_reg == 32'(WD_STEP - 1);

  // one wait cycle per access
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // config registers; illegal values keep the old one
  always_ff @(posedge clk) begin
    if (rst) begin
      in2_func_reg <= RST_IN2_FUNC;
      in3_func_reg <= RST_IN3_FUNC;
      input_four_function <= RST_IN4_FUNC; // [RULE_18]
      monitor_output_source <= RST_MON_SRC; // [RULE_01]
      monitor_output_gain <= RST_MON_GAIN;
      network_node_address <= RST_NODE_ADDR;
      serial_watchdog_time <= RST_WD_TIME; // [RULE_16]
      watchdog_expiry_action <= RST_WD_ACTION;
    end else if (wr) begin
      if (avs_address == OFF_INPUT_FUNC && avs_byteenable[0]) begin
        if (func_legal(avs_writedata[2:0])) in2_func_reg <= avs_writedata[2:0];
        if (func_legal(avs_writedata[6:4])) in3_func_reg <= avs_writedata[6:4];
      end
      if (avs_address == OFF_INPUT_FUNC && avs_byteenable[1] &&
          func_legal(avs_writedata[10:8])) begin
        input_four_function <= avs_writedata[10:8]; // [RULE_18]
      end
      if (avs_address == OFF_MONITOR && avs_byteenable[0] &&
          avs_writedata[2:0] <= MON_THERMAL) begin
        monitor_output_source <= avs_writedata[2:0];
      end
      if (avs_address == OFF_MONITOR && avs_byteenable[1]) begin
        monitor_output_gain <= avs_writedata[15:8]; // [RULE_02]
      end
      if (avs_address == OFF_NODE && avs_byteenable[0] &&
          avs_writedata[4:0] >= NODE_ADDR_MIN && avs_writedata[4:0] <= NODE_ADDR_MAX &&
          avs_writedata[7:5] == 3'h0) begin
        network_node_address <= avs_writedata[4:0]; // [RULE_15]
      end
      if (avs_address == OFF_WATCHDOG && avs_byteenable[0] &&
          avs_writedata[5:0] <= WD_TIME_MAX) begin
        serial_watchdog_time <= avs_writedata[5:0]; // [RULE_16]
      end
      if (avs_address == OFF_WATCHDOG && avs_byteenable[1] &&
          avs_writedata[9:8] != 2'h0) begin
        watchdog_expiry_action <= avs_writedata[9:8]; // [RULE_19]
      end
    end
  end

  // refused source change starts the display flash
  always_ff @(posedge clk) begin
    if (rst) begin
      command_source_select <= RST_CMD_SOURCE; // [RULE_07]
      flash_cnt_reg <= 32'h0000_0000;
    end else begin
      if (wr && avs_address == OFF_CONTROL && avs_byteenable[0] &&
          avs_writedata[0] != command_source_select) begin
        if (motor_stopped && !first_digital_input) begin
          command_source_select <= avs_writedata[0]; // [RULE_08]
        end else begin
          flash_cnt_reg <= 32'(FLASH_LEN); // [RULE_08]
        end
      end else if (flash_cnt_reg != 32'h0000_0000) begin
        flash_cnt_reg <= flash_cnt_reg - 32'h0000_0001;
      end
    end
  end

  // one-cycle panel pulses
  always_ff @(posedge clk) begin
    if (rst) begin
      panel_start_reg <= 1'b0;
      panel_stop_reg <= 1'b0;
      panel_reset_reg <= 1'b0;
    end else begin
      panel_start_reg <= wr && avs_address == OFF_PANEL_CMD && avs_byteenable[0] &&
                         avs_writedata[0];
      panel_stop_reg <= wr && avs_address == OFF_PANEL_CMD && avs_byteenable[0] &&
                        avs_writedata[1];
      panel_reset_reg <= wr && avs_address == OFF_PANEL_CMD && avs_byteenable[0] &&
                         avs_writedata[2];
    end
  end

  // start/stop latch; stop wins over start
  always_ff @(posedge clk) begin
    if (rst) begin
      run_reg <= 1'b0;
      din_reg <= dins;
    end else begin
      din_reg <= dins;
      if (emergency_stop || ramp_stop) begin
        run_reg <= 1'b0;
      end else if (!command_source_select) begin
        if (in2_func_reg == FUNC_SPECIAL) begin
          if (!second_digital_input) run_reg <= 1'b0; // [RULE_06]
          else if (first_digital_input) run_reg <= 1'b1; // [RULE_06]
        end else begin
          run_reg <= first_digital_input; // [RULE_06]
        end
      end else begin
        if (panel_stop_reg || serial_stop) run_reg <= 1'b0; // [RULE_07]
        else if (panel_start_reg || serial_start) run_reg <= 1'b1; // [RULE_07]
      end
    end
  end

  // watchdog counts only when enabled and restarts on our telegrams
  always_ff @(posedge clk) begin
    if (rst) begin
      wd_cycle_reg <= 32'h0000_0000;
      wd_sec_reg <= 6'h00;
    end else if (serial_watchdog_time == 6'h00 || telegram_ours) begin
      wd_cycle_reg <= 32'h0000_0000; // [RULE_21]
      wd_sec_reg <= 6'h00;
    end else if (!serial_timeout_error) begin
      if (wd_cycle_reg == 32'(WD_STEP - 1)) begin
        wd_cycle_reg <= 32'h0000_0000;
        if (wd_sec_reg != serial_watchdog_time) wd_sec_reg <= wd_sec_reg + 6'h01; // [RULE_16]
      end else begin
        wd_cycle_reg <= wd_cycle_reg + 32'h0000_0001;
      end
    end
  end

  // sticky errors; set wins over reset
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_timeout_error <= 1'b0;
      external_error <= 1'b0;
      ramp_stop <= 1'b0;
    end else begin
      if (wd_expire) begin
        serial_timeout_error <= 1'b1; // [RULE_16]
        ramp_stop <= watchdog_expiry_action == ACT_RAMP; // [RULE_19]
      end else if (reset_req) begin
        serial_timeout_error <= 1'b0; // [RULE_14]
        ramp_stop <= 1'b0;
      end
      if (ext_now) external_error <= 1'b1; // [RULE_13]
      else if (reset_req) external_error <= 1'b0; // [RULE_14]
    end
  end

  // output flops
  always_ff @(posedge clk) begin
    if (rst) begin
      run_cmd <= 1'b0;
      inching_command <= 1'b0;
      reverse_cmd <= 1'b0;
      emergency_stop <= 1'b0;
      firing_enable <= 1'b0;
      telegram_accept <= 1'b0;
      display_flash <= 1'b0;
    end else begin
      run_cmd <= run_reg && !emergency_stop;
      inching_command <= command_source_select ? serial_inching : // [RULE_09]
                         (input_four_function == FUNC_SPECIAL && fourth_digital_input);
      reverse_cmd <= command_source_select ? serial_reverse : // [RULE_10]
                     (in3_func_reg == FUNC_SPECIAL && third_digital_input);
      emergency_stop <= ge_open || // [RULE_11]
                        (command_source_select && !serial_enable) || // [RULE_12]
                        (serial_timeout_error && watchdog_expiry_action == ACT_EMERGENCY); // [RULE_19]
      firing_enable <= all_ge_closed && !external_error && // [RULE_20]
                       !(command_source_select && !serial_enable) &&
                       !(serial_timeout_error && watchdog_expiry_action == ACT_EMERGENCY);
      telegram_accept <= telegram_ours; // [RULE_15]
      display_flash <= flash_cnt_reg != 32'h0000_0000;
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    case (avs_address)
      OFF_CONTROL: rdata_next = {31'h0, command_source_select};
      OFF_INPUT_FUNC: rdata_next = {21'h0, input_four_function, 1'b0, in3_func_reg, 1'b0,
                                    in2_func_reg};
      OFF_MONITOR: rdata_next = {16'h0, monitor_output_gain, 5'h0, monitor_output_source};
      OFF_NODE: rdata_next = {27'h0, network_node_address};
      OFF_WATCHDOG: rdata_next = {22'h0, watchdog_expiry_action, 2'h0, serial_watchdog_time};
      OFF_STATUS: rdata_next = {24'h0, any_ge, display_flash, firing_enable, emergency_stop,
                                run_cmd, 1'b0, external_error, serial_timeout_error};
      OFF_LINK: rdata_next = {26'h0, wd_sec_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rdata_next;
    end
  end

  monitor_scaler u_scaler (
    .clk(clk),
    .rst(rst),
    .source(monitor_output_source),
    .gain(monitor_output_gain),
    .switch_current(switch_current),
    .output_voltage(output_voltage),
    .power_factor(power_factor),
    .motor_thermal_state(motor_thermal_state),
    .code(monitor_code)
  );
endmodule

// ==== verification/motor_cmd_properties.sv ====
// port-level property checks
`timescale 1ns/1ps
module motor_cmd_checker #(
  parameter int WD_STEP = 20,
  parameter int FLASH_LEN = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic telegram_valid,
  input wire logic telegram_accept,
  input wire logic [7:0] monitor_code,
  input wire logic run_cmd,
  input wire logic emergency_stop,
  input wire logic ramp_stop,
  input wire logic firing_enable,
  input wire logic serial_timeout_error,
  input wire logic display_flash
);
  int flash_len;
  int quiet_len;
  always_ff @(posedge clk) begin
    if (rst || !display_flash) flash_len <= 0;
    else flash_len <= flash_len + 1;
  end
  // restarts on accept, saturates at 1000000 cycles
  always_ff @(posedge clk) begin
    if (rst || telegram_accept) quiet_len <= 0;
    else if (quiet_len < 1000000) quiet_len <= quiet_len + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_wait_once: assert property
    ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait");
  chk_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_reset_quiet: assert property
    ($fell(rst) |-> monitor_code == 8'h00 && !run_cmd && avs_waitrequest)
    else $error("outputs not idle after reset");
  chk_accept_cause: assert property
    (telegram_accept |-> $past(telegram_valid))
    else $error("accept without a telegram");
  chk_estop_fire: assert property
    (emergency_stop |-> !firing_enable)
    else $error("firing during emergency stop");
  chk_ramp_cause: assert property
    ($rose(ramp_stop) |-> ##[0:1] serial_timeout_error)
    else $error("ramp stop without timeout");
  chk_alive_quiet: assert property
    (telegram_accept && !serial_timeout_error |=> !serial_timeout_error [*8])
    else $error("timeout after accepted telegram");
  chk_flash_len: assert property
    ($fell(display_flash) |-> flash_len == FLASH_LEN)
    else $error("display flash length wrong");
  chk_timeout_late: assert property
    ($rose(serial_timeout_error) |-> quiet_len >= WD_STEP - 2)
    else $error("timeout too early");
  cover property ($rose(display_flash));
  cover property ($rose(serial_timeout_error));
  cover property ($rose(emergency_stop));
endmodule

bind motor_command_source_logic motor_cmd_checker #(.WD_STEP(WD_STEP), .FLASH_LEN(FLASH_LEN))
  checks (.clk, .rst, .avs_read, .avs_write, .avs_waitrequest, .telegram_valid, .telegram_accept,
  .monitor_code, .run_cmd, .emergency_stop, .ramp_stop, .firing_enable, .serial_timeout_error,
  .display_flash);

// ==== verification/serial_master_model.sv ====
// serial master that sends addressed telegrams at a set interval
`timescale 1ns/1ps
module serial_master_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] target,
  input wire logic [7:0] period,
  output logic telegram_valid,
  output logic [4:0] telegram_address
);
  logic [7:0] gap_reg;
  // a zero period models a master that has gone silent
  always_ff @(posedge clk) begin
    if (rst) begin
      gap_reg <= 8'h00;
      telegram_valid <= 1'b0;
      telegram_address <= 5'h15;
    end else if (period != 8'h00 && gap_reg + 8'h01 >= period) begin
      gap_reg <= 8'h00;
      telegram_valid <= 1'b1;
      telegram_address <= target;
    end else begin
      gap_reg <= gap_reg + 8'h01;
      telegram_valid <= 1'b0;
      // unqualified address toggles to expose stale use
      telegram_address <= ~telegram_address;
    end
  end
endmodule

// ==== verification/testbench.sv ====
// self-checking bench
`timescale 1ns/1ps
module testbench;
  import motor_cmd_pkg::*;
  localparam int RUN = 0, INCH = 1, REV = 2, ESTOP = 3, RAMP = 4, FIRE = 5, EXT = 6, TO = 7;
  localparam int ACC = 8, FLASH = 9;
  logic clk, rst = 1, avs_read = 0, avs_write = 0, motor_stopped = 1, serial_enable = 1;
  logic first_digital_input = 0, second_digital_input = 0, fourth_digital_input = 0;
  logic third_digital_input = 1, serial_start = 0, serial_stop = 0, serial_inching = 0;
  logic serial_reverse = 0, serial_error_reset = 0, avs_waitrequest, telegram_valid;
  logic run_cmd, inching_command, reverse_cmd, emergency_stop, ramp_stop, firing_enable;
  logic external_error, serial_timeout_error, telegram_accept, display_flash;
  logic [7:0] avs_address = 8'h00, period = 8'h00, monitor_code;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdat;
  logic [3:0] avs_byteenable = 4'hF;
  logic [4:0] target = 5'h01, telegram_address;
  logic [11:0] switch_current = 12'h0, output_voltage = 12'h0;
  logic [11:0] power_factor = 12'h0, motor_thermal_state = 12'h0;
  int err_total = 0, n_checks = 0;
  string nm[10] = '{"run", "inching", "reverse", "estop", "ramp", "firing", "ext error",
    "timeout", "accept", "flash"};
  logic [7:0] offs[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'hF0};
  logic [31:0] rvals[8] = '{32'h1, 32'h21, 32'h6400, 32'h1, 32'h100, 32'h0, 32'h0, 32'h0};
  wire logic [9:0] flags = {display_flash, telegram_accept, serial_timeout_error,
    external_error, firing_enable, ramp_stop, emergency_stop, reverse_cmd, inching_command,
    run_cmd};

  motor_command_source_logic #(.WD_STEP(20), .FLASH_LEN(10)) DUT (.clk, .rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .first_digital_input, .second_digital_input, .third_digital_input, .fourth_digital_input,
    .motor_stopped, .telegram_valid, .telegram_address, .serial_start, .serial_stop,
    .serial_inching, .serial_reverse, .serial_enable, .serial_error_reset, .switch_current,
    .output_voltage, .power_factor, .motor_thermal_state, .monitor_code, .run_cmd,
    .inching_command, .reverse_cmd, .emergency_stop, .ramp_stop, .firing_enable,
    .external_error, .serial_timeout_error, .telegram_accept, .display_flash);
  serial_master_model master (.clk, .rst, .target, .period, .telegram_valid, .telegram_address);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      err_total++;
      summarize();
    end
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0);
    check_val(what, exp, rdat);
  endtask

  // hold: keep e for n cycles; else reach e within n
  task automatic chk(input int i, input logic e, input int n, input bit hold);
    bit ok;
    ok = hold;
    repeat (n) begin
      @(negedge clk);
      if (hold) ok &= (flags[i] === e);
      else if (flags[i] === e) begin
        ok = 1'b1;
        break;
      end
    end
    n_checks++;
    if (!ok) begin
      err_total++;
      $display("unexpected %s: expected %b, seen %b", nm[i], e, flags[i]);
      if (!hold) summarize();
    end
    @(posedge clk);
  endtask

  task automatic mon(input logic [2:0] s, input int g, input int p);
    int e;
    wr(8'h08, {16'h0, 8'(g), 5'h0, s});
    switch_current <= 12'(p * 5);
    output_voltage <= 12'(p);
    power_factor <= 12'(p);
    motor_thermal_state <= 12'(p * 5 / 2);
    repeat (3) @(posedge clk);
    e = p * 255 * g / 10000;
    check_val("monitor code", s == 3'h0 ? 0 : (e > 255 ? 255 : e), {24'h0, monitor_code});
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wr(8'hF0, 32'hFFFF_FFFF);
    foreach (offs[i]) rd(offs[i], rvals[i], $sformatf("register %h", offs[i]));
    chk(TO, 1'b0, 100, 1'b1);
    for (int s = 0; s < 5; s++) mon(3'(s), 100, 100);
    for (int s = 1; s < 5; s++) mon(3'(s), 100, 50);
    mon(3'h1, 200, 100);
    mon(3'h3, 50, 50);
    mon(3'h4, 150, 80);
    mon(3'h2, 130, 60);
    wr(8'h0C, 32'h5);
    wr(8'h0C, 32'h1F);
    wr(8'h0C, 32'h0);
    rd(8'h0C, 32'h5, "node address");
    target <= 5'h05;
    period <= 8'h0A;
    chk(ACC, 1'b1, 30, 1'b0);
    target <= 5'h01;
    chk(ACC, 1'b0, 40, 1'b1);
    target <= 5'h05;
    wr(8'h10, 32'h38);
    rd(8'h10, 32'h100, "watchdog setting");
    for (int a = 1; a < 4; a++) begin
      wr(8'h10, (a << 8) | 2);
      wr(8'h14, 32'h4);
      chk(TO, 1'b0, 120, 1'b1);
      period <= 8'h00;
      chk(TO, 1'b1, 150, 1'b0);
      chk(RAMP, a == 2, 1, 1'b1);
      chk(ESTOP, a == 3, 1, 1'b1);
      period <= 8'h0A;
    end
    serial_error_reset <= 1'b1;
    @(posedge clk);
    serial_error_reset <= 1'b0;
    chk(TO, 1'b0, 5, 1'b0);
    wr(8'h10, 32'h100);
    first_digital_input <= 1'b1;
    chk(RUN, 1'b0, 20, 1'b1);
    wr(8'h14, 32'h1);
    chk(RUN, 1'b1, 10, 1'b0);
    serial_stop <= 1'b1;
    @(posedge clk);
    serial_stop <= 1'b0;
    chk(RUN, 1'b0, 10, 1'b0);
    serial_start <= 1'b1;
    serial_inching <= 1'b1;
    serial_reverse <= 1'b1;
    @(posedge clk);
    serial_start <= 1'b0;
    chk(RUN, 1'b1, 10, 1'b0);
    chk(INCH, 1'b1, 10, 1'b0);
    chk(REV, 1'b1, 10, 1'b0);
    wr(8'h14, 32'h2);
    motor_stopped <= 1'b0;
    wr(8'h00, 32'h0);
    chk(FLASH, 1'b1, 5, 1'b0);
    rd(8'h00, 32'h1, "source select");
    chk(FLASH, 1'b0, 20, 1'b0);
    motor_stopped <= 1'b1;
    wr(8'h00, 32'h0);
    chk(FLASH, 1'b1, 5, 1'b0);
    chk(FLASH, 1'b0, 20, 1'b0);
    first_digital_input <= 1'b0;
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h0, "source select");
    chk(FLASH, 1'b0, 10, 1'b1);
    first_digital_input <= 1'b1;
    chk(RUN, 1'b1, 10, 1'b0);
    chk(INCH, 1'b0, 5, 1'b1);
    chk(REV, 1'b0, 5, 1'b1);
    first_digital_input <= 1'b0;
    chk(RUN, 1'b0, 10, 1'b0);
    wr(8'h04, 32'h441);
    fourth_digital_input <= 1'b1;
    chk(INCH, 1'b1, 10, 1'b0);
    chk(REV, 1'b1, 10, 1'b0);
    third_digital_input <= 1'b0;
    chk(REV, 1'b0, 10, 1'b0);
    third_digital_input <= 1'b1;
    fourth_digital_input <= 1'b0;
    wr(8'h04, 32'h21);
    third_digital_input <= 1'b0;
    chk(EXT, 1'b1, 10, 1'b0);
    third_digital_input <= 1'b1;
    chk(EXT, 1'b1, 10, 1'b1);
    second_digital_input <= 1'b1;
    repeat (3) @(posedge clk);
    second_digital_input <= 1'b0;
    chk(EXT, 1'b0, 10, 1'b0);
    second_digital_input <= 1'b1;
    fourth_digital_input <= 1'b1;
    wr(8'h04, 32'h323);
    chk(ESTOP, 1'b0, 10, 1'b0);
    fourth_digital_input <= 1'b0;
    chk(ESTOP, 1'b1, 10, 1'b0);
    chk(FIRE, 1'b0, 1, 1'b1);
    wr(8'h00, 32'h1);
    fourth_digital_input <= 1'b1;
    chk(ESTOP, 1'b0, 10, 1'b0);
    serial_enable <= 1'b0;
    chk(FIRE, 1'b0, 10, 1'b0);
    serial_enable <= 1'b1;
    second_digital_input <= 1'b0;
    chk(ESTOP, 1'b1, 10, 1'b0);
    summarize();
  end
endmodule
